//--- logic/cfh_pkg.sv
package cfh_pkg;

  // ----------------------------------------
  // interface modes
  // ----------------------------------------
  typedef enum logic [1:0] {
    CFH_MODE_MEM = 2'h0,
    CFH_MODE_IO = 2'h1,
    CFH_MODE_IDE = 2'h2
  } cfh_mode_e;

  // ----------------------------------------
  // access sequencer states
  // ----------------------------------------
  typedef enum logic [3:0] {
    CFH_ST_IDLE = 4'h1,
    CFH_ST_SETUP = 4'h2,
    CFH_ST_STROBE = 4'h4,
    CFH_ST_HOLD = 4'h8
  } cfh_st_e;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CFH_CLK_NS = 5;
  localparam int CFH_SETUP_NS = 30;
  localparam int CFH_ACT_NS = 165;
  localparam int CFH_HOLD_NS = 20;
  localparam logic [5:0] CFH_SETUP_CYC = 6'((CFH_SETUP_NS + CFH_CLK_NS - 1) / CFH_CLK_NS);
  localparam logic [5:0] CFH_ACT_CYC = 6'((CFH_ACT_NS + CFH_CLK_NS - 1) / CFH_CLK_NS);
  localparam logic [5:0] CFH_HOLD_CYC = 6'((CFH_HOLD_NS + CFH_CLK_NS - 1) / CFH_CLK_NS);

  // ----------------------------------------
  // address layout
  // ----------------------------------------
  localparam int CFH_ADDR_W = 11;
  localparam int CFH_TASK_SEL_W = 3;
  localparam logic [2:0] CFH_TASK_DATA_REG = 3'h0;
  localparam logic [7:0] CFH_IDE_UPPER_ADDR = 8'h00;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic wr;
    logic attr;
    logic aux;
    logic wide;
    logic [10:0] addr;
    logic [15:0] wdata;
  } cfh_req_s;

  typedef struct packed {
    logic [10:0] addr;
    logic reg_n;
    logic ce1_n;
    logic ce2_n;
    logic oe_n;
    logic we_n;
    logic iord_n;
    logic iowr_n;
  } cfh_pins_s;

  localparam cfh_pins_s CFH_PINS_IDLE = '{
    addr: 11'h000, reg_n: 1'b1, ce1_n: 1'b1, ce2_n: 1'b1,
    oe_n: 1'b1, we_n: 1'b1, iord_n: 1'b1, iowr_n: 1'b1
  };

endpackage : cfh_pkg

//--- logic/cfh_alert.sv
`timescale 1ns/1ps
module cfh_alert
  import cfh_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // alert line and control
  input wire logic enable_i,
  input wire logic level_i,
  input wire logic clear_i,
  output logic flag_o
);

  typedef struct packed {
    logic prev;
    logic flag;
  } cfh_alert_s;

  cfh_alert_s s_r;
  cfh_alert_s s_nxt;

  // ----------------------------------------
  // sticky capture, set wins over clear
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.prev = level_i;
    if (clear_i) begin
      s_nxt.flag = 1'b0;
    end
    if (enable_i && s_r.prev && !level_i) begin
      s_nxt.flag = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      s_r <= '{prev: 1'b1, flag: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign flag_o = s_r.flag;

  a_alert_capture: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    enable_i && s_r.prev && !level_i |=> flag_o)
    else $error("alert edge not captured");

endmodule : cfh_alert

//--- logic/cfh_host.sv
// Function
// - in IDE mode host grounds address lines ten down to three.
// - in IDE mode pass-diagnostic pin is a two-way handshake signal.
// - in IDE mode drive-active/peer-present pin is a two-way handshake signal.
// - card grounds both detect lines; host sees insertion only when both low.
// - an 8-bit host may leave upper data lanes and second enable open; in IDE mode host still drives second enable for aux registers.
// - in IDE mode task register accesses use low byte; data is 16-bit.
`timescale 1ns/1ps
module cfh_host
  import cfh_pkg::*;
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // user configuration
  input wire cfh_mode_e mode_i,
  input wire logic bus8_i,
  // user request and answer
  input wire logic req_valid_i,
  input wire cfh_req_s req_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [15:0] rsp_data_o,
  // user status
  output logic inserted_o,
  output logic batt_ok_o,
  output logic alert_o,
  input wire logic alert_clr_i,
  // user handshake control
  input wire logic pass_diag_assert_i,
  input wire logic drive_active_assert_i,
  output logic pass_diag_seen_o,
  output logic drive_active_seen_o,
  // card control pins
  output cfh_pins_s pins_o,
  // card data pins
  input wire logic [15:0] data_i,
  output logic [15:0] data_o,
  output logic [15:0] data_oe_o,
  // card status pins
  input wire logic insert_detect_a_i,
  input wire logic insert_detect_b_i,
  input wire logic pin46_i,
  output logic pin46_o,
  output logic pin46_oe_o,
  input wire logic pin45_i,
  output logic pin45_o,
  output logic pin45_oe_o
);

  typedef struct packed {
    cfh_st_e st;
    cfh_mode_e mode;
    logic [5:0] cnt;
    cfh_req_s req;
    logic wide;
    cfh_pins_s pins;
    logic [15:0] dout;
    logic [15:0] doe;
    logic ready;
    logic rsp_v;
    logic [15:0] rdata;
    logic inserted;
    logic batt_ok;
    logic pd_oe;
    logic da_oe;
    logic pd_seen;
    logic da_seen;
  } cfh_state_s;

  cfh_state_s s_r;
  cfh_state_s s_nxt;
  logic alert_w;

  // ----------------------------------------
  // pin decode for one access
  // ----------------------------------------
  function automatic cfh_pins_s cfh_pins(input cfh_mode_e mode, input cfh_req_s rq,
                                         input logic wide, input logic strobe);
    cfh_pins_s p;
    p = CFH_PINS_IDLE;
    unique case (mode)
      CFH_MODE_MEM: begin
        p.addr = rq.addr;
        p.reg_n = !rq.attr;
        p.ce1_n = 1'b0;
        p.ce2_n = !wide;
        p.oe_n = !(strobe && !rq.wr);
        p.we_n = !(strobe && rq.wr);
      end
      CFH_MODE_IO: begin
        p.addr = rq.addr;
        p.reg_n = 1'b0;
        p.ce1_n = 1'b0;
        p.ce2_n = !wide;
        p.iord_n = !(strobe && !rq.wr);
        p.iowr_n = !(strobe && rq.wr);
      end
      CFH_MODE_IDE: begin
        p.addr = {CFH_IDE_UPPER_ADDR, rq.addr[CFH_TASK_SEL_W-1:0]};
        p.ce1_n = rq.aux;
        p.ce2_n = !rq.aux;
        p.iord_n = !(strobe && !rq.wr);
        p.iowr_n = !(strobe && rq.wr);
      end
      default: begin
        p = CFH_PINS_IDLE;
      end
    endcase
    return p;
  endfunction : cfh_pins

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.rsp_v = 1'b0;
    s_nxt.inserted = !insert_detect_a_i && !insert_detect_b_i;
    s_nxt.batt_ok = (s_r.mode == CFH_MODE_MEM) && pin46_i && pin45_i;
    s_nxt.pd_seen = (s_r.mode == CFH_MODE_IDE) && !pin46_i;
    s_nxt.da_seen = (s_r.mode == CFH_MODE_IDE) && !pin45_i;
    unique case (s_r.st)
      CFH_ST_IDLE: begin
        if (!req_valid_i || !s_r.ready) begin
          s_nxt.mode = mode_i;
        end
        if (req_valid_i && s_r.ready) begin
          s_nxt.req = req_i;
          if (s_r.mode == CFH_MODE_IDE) begin
            s_nxt.wide = req_i.wide && !bus8_i && !req_i.aux &&
                         (req_i.addr[2:0] == CFH_TASK_DATA_REG);
          end else begin
            s_nxt.wide = req_i.wide && !bus8_i;
          end
          s_nxt.st = CFH_ST_SETUP;
          s_nxt.cnt = CFH_SETUP_CYC - 6'h01;
          s_nxt.pins = cfh_pins(s_r.mode, req_i, s_nxt.wide, 1'b0);
          s_nxt.dout = req_i.wdata;
          s_nxt.doe = req_i.wr ? (s_nxt.wide ? 16'hFFFF : 16'h00FF) : 16'h0000;
        end
      end
      CFH_ST_SETUP: begin
        s_nxt.cnt = s_r.cnt - 6'h01;
        if (s_r.cnt == 6'h00) begin
          s_nxt.st = CFH_ST_STROBE;
          s_nxt.cnt = CFH_ACT_CYC - 6'h01;
          s_nxt.pins = cfh_pins(s_r.mode, s_r.req, s_r.wide, 1'b1);
        end
      end
      CFH_ST_STROBE: begin
        s_nxt.cnt = s_r.cnt - 6'h01;
        if (s_r.cnt == 6'h00) begin
          s_nxt.st = CFH_ST_HOLD;
          s_nxt.cnt = CFH_HOLD_CYC - 6'h01;
          s_nxt.pins = cfh_pins(s_r.mode, s_r.req, s_r.wide, 1'b0);
          s_nxt.rdata = s_r.wide ? data_i : {8'h00, data_i[7:0]};
        end
      end
      CFH_ST_HOLD: begin
        s_nxt.cnt = s_r.cnt - 6'h01;
        if (s_r.cnt == 6'h00) begin
          s_nxt.st = CFH_ST_IDLE;
          s_nxt.pins = CFH_PINS_IDLE;
          s_nxt.doe = 16'h0000;
          s_nxt.rsp_v = 1'b1;
        end
      end
      default: begin
        s_nxt.st = CFH_ST_IDLE;
        s_nxt.pins = CFH_PINS_IDLE;
        s_nxt.doe = 16'h0000;
      end
    endcase
    // handshake drive follows the mode that will be held, never a stale one
    s_nxt.pd_oe = (s_nxt.mode == CFH_MODE_IDE) && pass_diag_assert_i;
    s_nxt.da_oe = (s_nxt.mode == CFH_MODE_IDE) && drive_active_assert_i;
    s_nxt.ready = (s_nxt.st == CFH_ST_IDLE) && s_nxt.inserted;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rstn_i) begin
      s_r <= '{st: CFH_ST_IDLE, mode: CFH_MODE_MEM, cnt: 6'h00, req: '0, wide: 1'b0,
               pins: CFH_PINS_IDLE, dout: 16'h0000, doe: 16'h0000, ready: 1'b0,
               rsp_v: 1'b0, rdata: 16'h0000, inserted: 1'b0, batt_ok: 1'b0,
               pd_oe: 1'b0, da_oe: 1'b0, pd_seen: 1'b0, da_seen: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // status-changed alert
  // ----------------------------------------
  cfh_alert u_alert (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .enable_i(s_r.mode == CFH_MODE_IO),
    .level_i(pin46_i),
    .clear_i(alert_clr_i),
    .flag_o(alert_w)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign req_ready_o = s_r.ready;
  assign rsp_valid_o = s_r.rsp_v;
  assign rsp_data_o = s_r.rdata;
  assign inserted_o = s_r.inserted;
  assign batt_ok_o = s_r.batt_ok;
  assign alert_o = alert_w;
  assign pass_diag_seen_o = s_r.pd_seen;
  assign drive_active_seen_o = s_r.da_seen;
  assign pins_o = s_r.pins;
  assign data_o = s_r.dout;
  assign data_oe_o = s_r.doe;
  assign pin46_o = 1'b0;
  assign pin46_oe_o = s_r.pd_oe;
  assign pin45_o = 1'b0;
  assign pin45_oe_o = s_r.da_oe;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  localparam int A_ACT = 33;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  a_ide_upper_ground: assert property (
    s_r.mode == CFH_MODE_IDE |-> pins_o.addr[10:3] == 8'h00)
    else $error("upper address not grounded in ide mode");

  a_insert_gate: assert property (
    req_ready_o |-> $past(!insert_detect_a_i && !insert_detect_b_i))
    else $error("ready without both detect lines low");

  a_narrow_lanes: assert property (
    !s_r.wide |-> data_oe_o[15:8] == 8'h00 &&
                  (s_r.mode == CFH_MODE_IDE || pins_o.ce2_n))
    else $error("upper lanes used on narrow access");

  a_ide_select_pick: assert property (
    s_r.mode == CFH_MODE_IDE && s_r.st != CFH_ST_IDLE |->
      pins_o.ce2_n == !s_r.req.aux && pins_o.ce1_n == s_r.req.aux)
    else $error("wrong ide chip select");

  a_task_byte_lane: assert property (
    s_r.mode == CFH_MODE_IDE && s_r.st != CFH_ST_IDLE && s_r.req.aux |-> !s_r.wide)
    else $error("aux register access went wide");

  a_mode_held: assert property (
    s_r.st != CFH_ST_IDLE && $past(s_r.st) != CFH_ST_IDLE |-> $stable(s_r.mode))
    else $error("mode changed during access");

  a_pass_diag_ide: assert property (
    pin46_oe_o |-> s_r.mode == CFH_MODE_IDE && $past(pass_diag_assert_i))
    else $error("pass diagnostic driven outside ide mode");

  a_drive_active_ide: assert property (
    pin45_oe_o |-> s_r.mode == CFH_MODE_IDE && $past(drive_active_assert_i))
    else $error("drive active driven outside ide mode");

  a_batt_mem_only: assert property (
    batt_ok_o |-> $past(s_r.mode == CFH_MODE_MEM && pin46_i && pin45_i))
    else $error("battery flag wrong");

  a_strobe_length: assert property (
    $fell(pins_o.iord_n & pins_o.iowr_n & pins_o.oe_n & pins_o.we_n) |->
      ##A_ACT $rose(pins_o.iord_n & pins_o.iowr_n & pins_o.oe_n & pins_o.we_n))
    else $error("strobe width wrong");

endmodule : cfh_host

//--- bench/cfh_card_model.sv
`timescale 1ns/1ps
module cfh_card_model
  import cfh_pkg::*;
(
  // host side pins
  input wire logic clk_i,
  input wire cfh_mode_e mode_i,
  input wire cfh_pins_s pins_i,
  input wire logic [15:0] dq_i,
  // card events
  input wire logic chg_i,
  input wire logic drive_act_i,
  // card drive
  output logic [15:0] dq_o,
  output logic p46_o,
  output logic p45_o
);
  logic [7:0] mem [int];
  logic wr_r = 1'b0;
  int k;
  logic wide;

  // ----------------------------------------
  // status lines, 1 means released to pull-up
  // ----------------------------------------
  assign p46_o = (mode_i == CFH_MODE_IO) ? !chg_i : 1'b1;
  assign p45_o = (mode_i == CFH_MODE_IDE) ? !drive_act_i : 1'b1;

  function automatic logic [7:0] rb(input int a);
    return mem.exists(a) ? mem[a] : 8'h00;
  endfunction : rb

  // ----------------------------------------
  // decode, storage and data drive
  // ----------------------------------------
  initial dq_o = 16'h0000;
  always @(posedge clk_i) begin
    wide = !pins_i.ce1_n && !pins_i.ce2_n;
    k = pins_i.reg_n ? int'(pins_i.addr) : 2048 + int'(pins_i.addr);
    if (mode_i == CFH_MODE_IO) k = 4096 + int'(pins_i.addr);
    if (mode_i == CFH_MODE_IDE) begin
      k = (pins_i.ce2_n ? 6144 : 8192) + int'(pins_i.addr[2:0]);
      wide = !pins_i.ce1_n && pins_i.addr[2:0] == 3'h0;
    end
    wr_r <= !pins_i.we_n || !pins_i.iowr_n;
    if (wr_r && pins_i.we_n && pins_i.iowr_n) begin
      mem[k] = dq_i[7:0];
      if (wide) mem[k + 1] = dq_i[15:8];
    end
    // released bus toggles so stale data never matches
    if (!pins_i.oe_n || !pins_i.iord_n) dq_o <= wide ? {rb(k + 1), rb(k)} : {8'h00, rb(k)};
    else dq_o <= ~dq_o;
  end
endmodule : cfh_card_model

//--- bench/tb.sv
`timescale 1ns/1ps
module tb;
  import cfh_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, bus8 = 1'b0, vld = 1'b0, clr = 1'b0;
  logic pda = 1'b0, dsa = 1'b0, chg = 1'b0, dsc = 1'b0, present = 1'b1;
  cfh_mode_e mode = CFH_MODE_MEM;
  cfh_req_s req = '0;
  cfh_req_s r;
  cfh_pins_s pins;
  logic rdy, rv, ins, batt, alrt, pds, dss, p46o, p46oe, p45o, p45oe, c46, c45;
  logic [15:0] rd16, dout, doe, cdq, bus;
  logic pin46, pin45;
  logic [7:0] rf [int];
  int seed = 32'h0E4A76CB;
  int miscompares = 0, num_checks = 0, cyc = 0;

  always #2.5 clk = ~clk;
  assign bus = (doe & dout) | (~doe & cdq);
  assign pin46 = p46oe ? p46o : c46;
  assign pin45 = p45oe ? p45o : c45;

  // ----------------------------------------
  // design and card
  // ----------------------------------------
  cfh_host i_cfh_host (.core_clk_i(clk), .rstn_i(rstn), .mode_i(mode), .bus8_i(bus8),
    .req_valid_i(vld), .req_i(req), .req_ready_o(rdy), .rsp_valid_o(rv), .rsp_data_o(rd16),
    .inserted_o(ins), .batt_ok_o(batt), .alert_o(alrt), .alert_clr_i(clr),
    .pass_diag_assert_i(pda), .drive_active_assert_i(dsa), .pass_diag_seen_o(pds),
    .drive_active_seen_o(dss),
    .pins_o(pins), .data_i(bus), .data_o(dout), .data_oe_o(doe),
    .insert_detect_a_i(!present), .insert_detect_b_i(!present),
    .pin46_i(pin46), .pin46_o(p46o), .pin46_oe_o(p46oe),
    .pin45_i(pin45), .pin45_o(p45o), .pin45_oe_o(p45oe));
  cfh_card_model i_cfh_card_model (.clk_i(clk), .mode_i(mode), .pins_i(pins), .dq_i(bus),
    .chg_i(chg), .drive_act_i(dsc), .dq_o(cdq), .p46_o(c46), .p45_o(c45));

  // ----------------------------------------
  // checking helpers
  // ----------------------------------------
  task automatic complete_run();
    if (miscompares == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask : chk

  function automatic int key(input cfh_req_s q);
    if (mode == CFH_MODE_IO) return 4096 + int'(q.addr);
    if (mode == CFH_MODE_IDE) return (q.aux ? 8192 : 6144) + int'(q.addr[2:0]);
    return (q.attr ? 2048 : 0) + int'(q.addr);
  endfunction : key

  function automatic logic [7:0] rb(input int a);
    return rf.exists(a) ? rf[a] : 8'h00;
  endfunction : rb

  task automatic acc(input cfh_req_s q);
    int n;
    int k;
    logic w;
    n = 0;
    while (!rdy && n < 100) begin
      @(negedge clk);
      n++;
    end
    req = q;
    vld = 1'b1;
    @(posedge clk);
    @(negedge clk);
    vld = 1'b0;
    n = 1;
    while (!rv && n < 60) begin
      if (n == 20) begin
        chk("strobe", 16'h0000, 16'(pins.oe_n & pins.iord_n & pins.we_n & pins.iowr_n));
        if (mode == CFH_MODE_IDE) chk("hi_addr", 16'h0000, 16'(pins.addr[10:3]));
        if (bus8) chk("hi_lane", 16'h0001, 16'({doe[15:8], pins.ce2_n}));
      end
      @(negedge clk);
      n++;
    end
    chk("latency", 16'd44, 16'(n));
    w = q.wide && !bus8 && (mode != CFH_MODE_IDE || (!q.aux && q.addr[2:0] == 3'h0));
    k = key(q);
    if (q.wr) begin
      rf[k] = q.wdata[7:0];
      if (w) rf[k + 1] = q.wdata[15:8];
    end else begin
      chk("rdata", w ? {rb(k + 1), rb(k)} : {8'h00, rb(k)}, rd16);
    end
  endtask : acc

  task automatic setm(input cfh_mode_e m, input logic b);
    mode = m;
    bus8 = b;
    repeat (3) @(negedge clk);
  endtask : setm

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      complete_run();
    end
  end

  initial begin
    repeat (5) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    chk("inserted", 16'h0001, 16'(ins));
    for (int m = 0; m < 3; m++) begin
      for (int b = 0; b < 2; b++) begin
        setm(cfh_mode_e'(m), b[0]);
        chk("batt", 16'(m == 0), 16'(batt));
        repeat (24) begin
          r = 31'($random(seed));
          r.wdata = 16'($random(seed));
          r.addr = r.addr & 11'h40F;
          if (r.wide) r.addr[0] = 1'b0;
          if (mode == CFH_MODE_IDE && bus8) begin
            r.aux = 1'b0;
            if (r.addr[2:0] == 3'h0) r.addr[0] = 1'b1;
          end
          if (mode == CFH_MODE_IDE) r.wide = !bus8 && !r.aux && r.addr[2:0] == 3'h0;
          acc(r);
        end
      end
    end
    setm(CFH_MODE_IO, 1'b0);
    chg = 1'b1;
    repeat (3) @(negedge clk);
    chk("alert", 16'h0001, 16'(alrt));
    chg = 1'b0;
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
    @(negedge clk);
    chk("alert_clr", 16'h0000, 16'(alrt));
    setm(CFH_MODE_IDE, 1'b0);
    pda = 1'b1;
    repeat (3) @(negedge clk);
    chk("pass_diag", 16'h0002, 16'({pds, pin46}));
    pda = 1'b0;
    dsc = 1'b1;
    repeat (3) @(negedge clk);
    chk("drive_active", 16'h0002, 16'({dss, pds}));
    dsc = 1'b0;
    repeat (3) @(negedge clk);
    chk("drive_active_idle", 16'h0001, 16'({dss, pin45}));
    dsa = 1'b1;
    repeat (3) @(negedge clk);
    chk("drive_active_host", 16'h0002, 16'({dss, pin45}));
    dsa = 1'b0;
    present = 1'b0;
    repeat (3) @(negedge clk);
    chk("removed", 16'h0000, 16'({ins, rdy}));
    complete_run();
  end
endmodule : tb
